// ===== shared/sbil_pkg.sv
// Constants, register map and state type for the secure boot image loader.
// Assumes a 50 MHz tile clock and APB register access with 32-bit data.
// Functional notes
// - While reset is low, hold in reset and enable pull-downs on all GPIO.
// - After reset release, run internal reset then boot within 15 to 150 us.
// - Boot from OTP when security bit 5 is set, else from serial flash.
// - Image: word count, count times four bytes, CRC; 0x0D15AB1E skips the check.
// - Word count and CRC fields arrive least significant byte first.
// - Program is written from the lowest RAM address and started there.
// - CRC covers word count and program bytes, never the CRC field.
// - Reflected 802.3 polynomial, all-ones start, result is inverted.
// - Security bit 0 blocks boundary-scan access to tile state and memory.
// - Security bit 1 blocks other tiles from processor state via switch.
// - Secure boot starts from OTP address zero, skipping the boot ROM.
// - Security bit 7 enables redundant OTP rows.
// - Security bits 8 to 11 inhibit programming of OTP sectors 0 to 3.
// - Security bit 12 inhibits all OTP programming, security register too.
// - Security bit 13 blocks boundary-scan read and write of the OTP.
// - Bits 21:15 are a software field; bits 31:22 are the user ID extension.
// - Security register loads from OTP before its settings take effect.
// - OTP image is copied to SRAM and run before any other code.
// - OTP holds four sectors of 512 rows of 32-bit words.
// - OTP programming uses address, data and control ports with own IDs.
// - User ID comes from security bits 31:22, zero when unprogrammed.
package sbil_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int BOOT_DLY_MIN_US = 15;
    localparam logic [11:0] BOOT_DLY_CYC =
        12'((BOOT_DLY_MIN_US * CLK_HZ + 999_999) / 1_000_000);

    // Security register fields
    localparam int SEC_JTAG_OFF     = 0;
    localparam int SEC_LINK_OFF     = 1;
    localparam int SEC_SECURE_BOOT  = 5;
    localparam int SEC_REDUNDANT    = 7;
    localparam int SEC_SECTOR_LOCK  = 8;
    localparam int SEC_MASTER_LOCK  = 12;
    localparam int SEC_JTAG_OTP_OFF = 13;
    localparam int SEC_GP_LSB       = 15;
    localparam int SEC_GP_MSB       = 21;
    localparam int SEC_UID_LSB      = 22;
    localparam int SEC_UID_MSB      = 31;
    localparam logic [31:0] SEC_RESET = 32'h0000_0000;

    // Image and CRC
    localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] CRC_SKIP = 32'h0d15_ab1e;
    localparam logic [31:0] RAM_BASE = 32'h0000_0000;
    localparam int RAM_AW = 15;

    // OTP geometry and programming port identifiers
    localparam int OTP_ROWS = 512;
    localparam int OTP_AW   = 11;
    localparam int OTP_SECT_LSB = 9;
    localparam logic [31:0] RES_OTP_ADDR = 32'h0010_0200;
    localparam logic [31:0] RES_OTP_DATA = 32'h0020_0100;
    localparam logic [31:0] RES_OTP_CTRL = 32'h0010_0300;

    // APB byte offsets
    localparam logic [7:0] REG_SEC      = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_OTP_ADDR = 8'h08;
    localparam logic [7:0] REG_OTP_DATA = 8'h0c;
    localparam logic [7:0] REG_OTP_CTRL = 8'h10;
    localparam logic [7:0] REG_CRC      = 8'h14;
    localparam logic [7:0] REG_SIZE     = 8'h18;
    localparam logic [7:0] REG_ID_ADDR  = 8'h1c;
    localparam logic [7:0] REG_ID_DATA  = 8'h20;
    localparam logic [7:0] REG_ID_CTRL  = 8'h24;

    localparam int CTRL_GO  = 0;
    localparam int CTRL_SEC = 1;
    localparam int STAT_LOADED  = 0;
    localparam int STAT_BOOTOTP = 1;
    localparam int STAT_RUN     = 2;
    localparam int STAT_FAIL    = 3;
    localparam int STAT_REFUSED = 4;
    localparam int STAT_BUSY    = 5;

    typedef enum logic [3:0] {
        S_DELAY, S_SEC_RD, S_SEC_WAIT, S_SIZE, S_PROG, S_CRC, S_CHECK, S_RUN, S_FAIL
    } sbil_state_t;
endpackage

// ===== verilog/sbil_crc32.sv
// Byte-serial reflected CRC-32 engine.
// Assumes one byte per enabled cycle; clear restarts from the all-ones value.
module sbil_crc32
    import sbil_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Byte stream
    input  wire logic        clear,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    // Result
    output logic      [31:0] crc_out
);
    logic [31:0] crc;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            crc <= CRC_INIT;
        end else if (en) begin
            crc <= crc_byte(crc, data);
        end
    end

    assign crc_out = ~crc;
endmodule

// ===== verilog/sbil_loader.sv
// Boot sequencer, image loader and security register decoder of one tile.
// Assumes flash and OTP ports run on clk; the APB slave answers without waits.
//
// Decided for this implementation: the APB register port and the register addresses.
module sbil_loader
    import sbil_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Serial flash byte stream
    input  wire logic [7:0]        flash_data,
    input  wire logic              flash_valid,
    output logic                   flash_ready,
    // OTP read port
    output logic                   otp_rd_req,
    output logic                   otp_rd_sec,
    output logic [OTP_AW-1:0]      otp_rd_addr,
    input  wire logic [31:0]       otp_rd_data,
    input  wire logic              otp_rd_valid,
    // OTP programming port
    output logic                   otp_prog_req,
    output logic                   otp_prog_sec,
    output logic [15:0]            otp_prog_addr,
    output logic [31:0]            otp_prog_data,
    output logic [15:0]            otp_prog_ctrl,
    input  wire logic              otp_prog_done,
    // SRAM write port and processor start
    output logic                   sram_we,
    output logic [RAM_AW-1:0]      sram_addr,
    output logic [31:0]            sram_wdata,
    output logic                   cpu_start,
    output logic                   cpu_run,
    output logic [31:0]            cpu_pc,
    // Security controls
    output logic                   gpio_pulldown_en,
    output logic                   jtag_block,
    output logic                   link_block,
    output logic                   otp_redundancy_en,
    output logic                   otp_jtag_block,
    output logic [6:0]             user_gp,
    output logic [9:0]             user_id
);
    sbil_state_t state;
    logic [11:0]       dly_cnt;
    logic [31:0]       sec;
    logic              sec_loaded;
    logic              boot_otp;
    logic [31:0]       acc;
    logic [1:0]        byte_idx;
    logic [31:0]       img_size;
    logic [31:0]       words_done;
    logic [31:0]       crc_stored;
    logic [31:0]       crc_result;
    logic [31:0]       otp_word;
    logic [2:0]        otp_cnt;
    logic              otp_pend;
    logic [OTP_AW-1:0] otp_row;
    logic              prog_busy;
    logic              refused;
    logic              consuming;
    logic              byte_avail;
    logic [7:0]        byte_data;
    logic              take;
    logic              word_done;
    logic [31:0]       assembled;
    logic              crc_en;
    logic              crc_pass;
    logic              wr_en;
    logic              rd_setup;
    logic              mapped;
    logic              prog_locked;
    logic [31:0]       next_prdata;
    logic [1:0]        prog_sector;

    // Byte source: flash stream, or OTP rows unpacked low byte first
    assign consuming  = (state == S_SIZE) || (state == S_PROG) || (state == S_CRC);
    assign byte_avail = boot_otp ? (otp_cnt != 3'h0) : flash_valid;
    assign byte_data  = boot_otp ? otp_word[7:0] : flash_data;
    assign take       = consuming && byte_avail;
    assign flash_ready = consuming && !boot_otp;
    assign word_done  = take && (byte_idx == 2'h3);
    assign assembled  = {byte_data, acc[31:8]};
    assign crc_en     = take && (state != S_CRC);
    assign crc_pass   = (crc_stored == CRC_SKIP) || (crc_stored == crc_result);

    sbil_crc32 u_crc (
        .clk     (clk),
        .rst_n   (rst_n),
        .clear   (state == S_SEC_WAIT),
        .en      (crc_en),
        .data    (byte_data),
        .crc_out (crc_result)
    );

    // Boot sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state      <= S_DELAY;
            dly_cnt    <= 12'h000;
            boot_otp   <= 1'b0;
            img_size   <= 32'h0000_0000;
            words_done <= 32'h0000_0000;
            crc_stored <= 32'h0000_0000;
        end else begin
            unique case (state)
                S_DELAY: begin
                    dly_cnt <= dly_cnt + 12'h001;
                    if (dly_cnt == BOOT_DLY_CYC - 12'h001) begin
                        state <= S_SEC_RD;
                    end
                end
                S_SEC_RD: state <= S_SEC_WAIT;
                S_SEC_WAIT: begin
                    if (otp_rd_valid) begin
                        boot_otp <= otp_rd_data[SEC_SECURE_BOOT];
                        state    <= S_SIZE;
                    end
                end
                S_SIZE: begin
                    if (word_done) begin
                        img_size <= assembled;
                        state    <= (assembled == 32'h0000_0000) ? S_CRC : S_PROG;
                    end
                end
                S_PROG: begin
                    if (word_done) begin
                        words_done <= words_done + 32'h0000_0001;
                        if (words_done == img_size - 32'h0000_0001) begin
                            state <= S_CRC;
                        end
                    end
                end
                S_CRC: begin
                    if (word_done) begin
                        crc_stored <= assembled;
                        state      <= S_CHECK;
                    end
                end
                S_CHECK: state <= crc_pass ? S_RUN : S_FAIL;
                S_RUN:   state <= S_RUN;
                S_FAIL:  state <= S_FAIL;
            endcase
        end
    end

    // Field assembly
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc      <= 32'h0000_0000;
            byte_idx <= 2'h0;
        end else if (take) begin
            acc      <= assembled;
            byte_idx <= byte_idx + 2'h1;
        end
    end

    // OTP reads: security row first, then image rows from address zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            otp_rd_req  <= 1'b0;
            otp_rd_sec  <= 1'b0;
            otp_rd_addr <= '0;
            otp_row     <= '0;
            otp_pend    <= 1'b0;
            otp_cnt     <= 3'h0;
            otp_word    <= 32'h0000_0000;
        end else begin
            otp_rd_req <= 1'b0;
            if (state == S_SEC_RD) begin
                otp_rd_req <= 1'b1;
                otp_rd_sec <= 1'b1;
            end else if (boot_otp && consuming && otp_cnt == 3'h0 && !otp_pend) begin
                otp_rd_req  <= 1'b1;
                otp_rd_sec  <= 1'b0;
                otp_rd_addr <= otp_row;
                otp_row     <= otp_row + OTP_AW'(1);
                otp_pend    <= 1'b1;
            end
            if (otp_pend && otp_rd_valid) begin
                otp_pend <= 1'b0;
                otp_word <= otp_rd_data;
                otp_cnt  <= 3'h4;
            end else if (take && boot_otp) begin
                otp_word <= {8'h00, otp_word[31:8]};
                otp_cnt  <= otp_cnt - 3'h1;
            end
        end
    end

    // SRAM load and processor start
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sram_we    <= 1'b0;
            sram_addr  <= '0;
            sram_wdata <= 32'h0000_0000;
            cpu_start  <= 1'b0;
            cpu_run    <= 1'b0;
            cpu_pc     <= RAM_BASE;
        end else begin
            sram_we    <= (state == S_PROG) && word_done;
            sram_addr  <= words_done[RAM_AW-1:0];
            sram_wdata <= assembled;
            cpu_start  <= (state == S_CHECK) && crc_pass;
            cpu_pc     <= RAM_BASE;
            if (state == S_CHECK && crc_pass) begin
                cpu_run <= 1'b1;
            end
        end
    end

    // Security register capture and decode; debug paths stay closed until loaded
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sec        <= SEC_RESET;
            sec_loaded <= 1'b0;
        end else if (state == S_SEC_WAIT && otp_rd_valid) begin
            sec        <= otp_rd_data;
            sec_loaded <= 1'b1;
        end else if (wr_en && paddr == REG_SEC && sec_loaded) begin
            sec[SEC_GP_MSB:SEC_GP_LSB] <= pwdata[SEC_GP_MSB:SEC_GP_LSB];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gpio_pulldown_en  <= 1'b1;
            jtag_block        <= 1'b1;
            link_block        <= 1'b1;
            otp_redundancy_en <= 1'b0;
            otp_jtag_block    <= 1'b1;
            user_gp           <= 7'h00;
            user_id           <= 10'h000;
        end else begin
            gpio_pulldown_en  <= 1'b0;
            jtag_block        <= !sec_loaded || sec[SEC_JTAG_OFF];
            link_block        <= !sec_loaded || sec[SEC_LINK_OFF];
            otp_redundancy_en <= sec_loaded && sec[SEC_REDUNDANT];
            otp_jtag_block    <= !sec_loaded || sec[SEC_JTAG_OTP_OFF];
            user_gp           <= sec[SEC_GP_MSB:SEC_GP_LSB];
            user_id           <= sec[SEC_UID_MSB:SEC_UID_LSB];
        end
    end

    // OTP programming through the address, data and control ports
    assign prog_sector = otp_prog_addr[OTP_SECT_LSB+1:OTP_SECT_LSB];
    assign prog_locked = !sec_loaded || sec[SEC_MASTER_LOCK] ||
        (!pwdata[CTRL_SEC] && sec[SEC_SECTOR_LOCK + 32'(prog_sector)]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            otp_prog_req  <= 1'b0;
            otp_prog_sec  <= 1'b0;
            otp_prog_addr <= 16'h0000;
            otp_prog_data <= 32'h0000_0000;
            otp_prog_ctrl <= 16'h0000;
            prog_busy     <= 1'b0;
            refused       <= 1'b0;
        end else begin
            otp_prog_req <= 1'b0;
            if (otp_prog_done) begin
                prog_busy <= 1'b0;
            end
            if (wr_en && paddr == REG_STATUS && pwdata[STAT_REFUSED]) begin
                refused <= 1'b0;
            end
            if (wr_en && paddr == REG_OTP_ADDR) begin
                otp_prog_addr <= pwdata[15:0];
            end
            if (wr_en && paddr == REG_OTP_DATA) begin
                otp_prog_data <= pwdata;
            end
            if (wr_en && paddr == REG_OTP_CTRL && pwdata[CTRL_GO]) begin
                // A refused attempt sets the flag even against a clear
                if (prog_locked || prog_busy) begin
                    refused <= 1'b1;
                end else begin
                    otp_prog_ctrl <= pwdata[15:0];
                    otp_prog_sec  <= pwdata[CTRL_SEC];
                    otp_prog_req  <= 1'b1;
                    prog_busy     <= 1'b1;
                end
            end
        end
    end

    // APB slave: zero wait states, data latched in the setup cycle
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign mapped   = (paddr[1:0] == 2'h0) && (paddr <= REG_ID_CTRL);
    assign pslverr  = psel && penable && !mapped;

    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            REG_SEC:      next_prdata = sec;
            REG_STATUS: begin
                next_prdata[STAT_LOADED]  = sec_loaded;
                next_prdata[STAT_BOOTOTP] = boot_otp;
                next_prdata[STAT_RUN]     = cpu_run;
                next_prdata[STAT_FAIL]    = (state == S_FAIL);
                next_prdata[STAT_REFUSED] = refused;
                next_prdata[STAT_BUSY]    = prog_busy;
            end
            REG_OTP_ADDR: next_prdata = {16'h0000, otp_prog_addr};
            REG_OTP_DATA: next_prdata = otp_prog_data;
            REG_OTP_CTRL: next_prdata = {16'h0000, otp_prog_ctrl};
            REG_CRC:      next_prdata = crc_result;
            REG_SIZE:     next_prdata = img_size;
            REG_ID_ADDR:  next_prdata = RES_OTP_ADDR;
            REG_ID_DATA:  next_prdata = RES_OTP_DATA;
            REG_ID_CTRL:  next_prdata = RES_OTP_CTRL;
            default:      next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

    // Assertions
    a_pulldown_release: assert property (@(posedge clk)
        $rose(rst_n) |-> gpio_pulldown_en ##1 !gpio_pulldown_en)
        else $error("pull-downs not held through reset");
    a_boot_delay_min: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_DELAY && dly_cnt < BOOT_DLY_CYC - 12'h001) |=> state == S_DELAY)
        else $error("boot started before the minimum delay");
    a_boot_source: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_SIZE) |-> boot_otp == sec[SEC_SECURE_BOOT])
        else $error("boot source disagrees with secure boot bit");
    a_crc_gate_start: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cpu_run) |-> $past(crc_stored) == CRC_SKIP
                           || $past(crc_stored) == $past(crc_result))
        else $error("program started with a bad CRC");
    a_crc_excludes: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_CRC && take) |=> $stable(crc_result))
        else $error("CRC field fed into the CRC");
    a_start_at_base: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_start |-> cpu_pc == RAM_BASE && cpu_run ##1 !cpu_start)
        else $error("start not at lowest RAM address");
    a_first_word_low: assert property (@(posedge clk) disable iff (!rst_n)
        (state == S_PROG && word_done && words_done == 32'h0) |=> sram_we && sram_addr == '0)
        else $error("first program word not at address zero");
    a_sec_first: assert property (@(posedge clk) disable iff (!rst_n)
        (sram_we || cpu_run) |-> sec_loaded)
        else $error("loading before security register");
    a_jtag_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (sec_loaded && sec[SEC_JTAG_OFF]) |=> jtag_block)
        else $error("boundary-scan access not blocked");
    a_master_lock: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_en && paddr == REG_OTP_CTRL && pwdata[CTRL_GO] && sec[SEC_MASTER_LOCK])
            |=> !otp_prog_req && refused)
        else $error("programming passed the master lock");
endmodule

// ===== sim/sbil_far_side.sv
// Far side model: embedded serial flash byte source and OTP array rows.
// Bench fills img, n, sec_word and idx while reset is held.
module sbil_far_side
    import sbil_pkg::*;
(
    // Clock and flash stream
    input  wire logic              clk,
    input  wire logic              flash_ready,
    output logic      [7:0]        flash_data,
    output logic                   flash_valid,
    // OTP read and programming ports
    input  wire logic              otp_rd_req,
    input  wire logic              otp_rd_sec,
    input  wire logic [OTP_AW-1:0] otp_rd_addr,
    output logic      [31:0]       otp_rd_data,
    output logic                   otp_rd_valid,
    input  wire logic              otp_prog_req,
    output logic                   otp_prog_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0]        img [0:15];
    logic [31:0]       sec_word;
    logic [2:0]        rq = '0;
    logic [2:0]        pq = '0;
    logic [OTP_AW-1:0] ra;
    logic              rs;
    int                n = 0;
    int                idx = 0;
    assign flash_valid = idx < n;
    // Released line shows the inverse of the last byte, never a stale copy
    assign flash_data = flash_valid ? img[idx] : ~img[n-1];
    assign otp_rd_valid = rq[2];
    assign otp_rd_data = !rq[2] ? ~sec_word : rs ? sec_word :
        {img[4*ra+3], img[4*ra+2], img[4*ra+1], img[4*ra]};
    assign otp_prog_done = pq[2];
    always @(posedge clk) begin
        rq <= {rq[1:0], otp_rd_req};
        pq <= {pq[1:0], otp_prog_req};
        if (otp_rd_req) begin
            rs <= otp_rd_sec;
            ra <= otp_rd_addr;
        end
        if (flash_valid && flash_ready) idx <= idx + 1;
    end
endmodule

// ===== sim/sbil_loader_tb.sv
// Self-checking bench for the boot loader and security decoder.
// Assumes a zero-wait APB slave and the far-side model beside it.
module sbil_loader_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sbil_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, otp_rd_data, otp_prog_data, sram_wdata, cpu_pc, r;
    logic pready, pslverr, flash_valid, flash_ready, otp_rd_req, otp_rd_sec, otp_rd_valid;
    logic otp_prog_req, otp_prog_sec, otp_prog_done, sram_we, cpu_start, cpu_run, e;
    logic gpio_pulldown_en, jtag_block, link_block, otp_redundancy_en, otp_jtag_block;
    logic [7:0] flash_data;
    logic [OTP_AW-1:0] otp_rd_addr;
    logic [15:0] otp_prog_addr, otp_prog_ctrl;
    logic [RAM_AW-1:0] sram_addr;
    logic [6:0] user_gp;
    logic [9:0] user_id;
    logic [31:0] ram [0:3];
    int err_total = 0, samples_checked = 0, prog_cnt = 0;
    localparam logic [31:0] W0 = 32'h1234_5678, W1 = 32'ha5c3_0f01;
    localparam logic [31:0] SECS [4] = '{32'h8012_2183, 32'h0000_0200, 32'h0000_1000, 32'h20};

    sbil_loader DUT (.*);
    sbil_far_side FAR (.*);

    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        if (sram_we === 1'b1) ram[sram_addr[1:0]] <= sram_wdata;
        if (otp_prog_req === 1'b1) prog_cnt <= prog_cnt + 1;
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task results;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            err_total++;
            results();
        end
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // Sector taken from address bits 10:9; s aims at the security register
    task prog(input logic [15:0] a, input logic s, input logic ok);
        int p;
        logic [31:0] cw;
        p = prog_cnt;
        cw = (32'(s) << CTRL_SEC) | (32'h1 << CTRL_GO);
        apb(1, REG_OTP_ADDR, {16'h0, a});
        apb(1, REG_OTP_DATA, 32'h5a5a_0001);
        apb(1, REG_OTP_CTRL, cw);
        repeat (6) @(posedge clk);
        check("prog issued", prog_cnt - p, ok);
        if (ok) check("prog addr", otp_prog_addr, a);
        if (ok) check("prog data", otp_prog_data, 32'h5a5a_0001);
        if (ok) check("prog ctrl", {otp_prog_sec, otp_prog_ctrl}, {s, cw[15:0]});
        apb(0, REG_STATUS, 0);
        check("refused", r[STAT_REFUSED], !ok);
        apb(1, REG_STATUS, 32'h1 << STAT_REFUSED);
    endtask

    function automatic logic [31:0] crc(input int m);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 0; i < m; i++) begin
            c ^= 32'(FAR.img[i]);
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return ~c;
    endfunction

    // Mode 0 good CRC, 1 corrupted CRC, 2 skip value
    task boot(input logic [31:0] sec, input int mode);
        logic [31:0] c;
        logic go;
        int k;
        go = mode != 1;
        rst_n <= 0;
        ram[0] = 'x;
        ram[1] = 'x;
        for (k = 0; k < 12; k++) FAR.img[k] = 8'((k < 4 ? 32'd2 : k < 8 ? W0 : W1) >> 8*(k%4));
        c = crc(12);
        c = mode == 1 ? c ^ 32'h1 : mode == 2 ? CRC_SKIP : c;
        for (k = 0; k < 4; k++) FAR.img[12+k] = 8'(c >> 8*k);
        FAR.n = 16;
        FAR.idx = 0;
        FAR.sec_word = sec;
        repeat (10) @(posedge clk);
        check("pulldown", gpio_pulldown_en, 1);
        check("jtag in reset", jtag_block, 1);
        rst_n <= 1;
        for (k = 0; k < 8000 && otp_rd_req !== 1'b1; k++) @(posedge clk);
        check("boot delay", k >= 749 && k <= 7500, 1);
        check("sec row first", otp_rd_sec, 1);
        for (k = 0; k < 400 && cpu_run !== 1'b1; k++) @(posedge clk);
        check("started", cpu_run, go);
        if (go) begin
            check("word0", ram[0], W0);
            check("word1", ram[1], W1);
            check("pc", cpu_pc, RAM_BASE);
        end
        apb(0, REG_STATUS, 0);
        check("fail flag", r[STAT_FAIL], !go);
        check("boot source", r[STAT_BOOTOTP], sec[5]);
        check("security", {jtag_block, link_block, otp_redundancy_en, otp_jtag_block, user_gp,
            user_id}, {sec[0], sec[1], sec[7], sec[13],
            sec[21:15], sec[31:22]});
        apb(0, REG_SIZE, 0);
        check("size", r, 32'd2);
        apb(0, REG_CRC, 0);
        check("crc", r, crc(12));
        prog(16'h0200, 0, !sec[12] && !sec[9]);
        prog(16'h0000, 0, !sec[12] && !sec[8]);
        prog(16'h0000, 1, !sec[12]);
    endtask

    initial begin
        for (int i = 0; i < 4; i++) boot(SECS[i], i == 3 ? 0 : i);
        for (int i = 0; i < 3; i++) begin
            apb(0, REG_ID_ADDR + 8'(4*i), 0);
            check("port id", r, i == 0 ? RES_OTP_ADDR : i == 1 ? RES_OTP_DATA : RES_OTP_CTRL);
        end
        apb(0, 8'h28, 0);
        check("unmapped data", r, 32'h0);
        check("unmapped error", e, 32'h1);
        apb(1, REG_SEC, 32'hffff_ffff);
        apb(0, REG_SEC, 0);
        check("sec write", r, 32'h003f_8020);
        results();
    end
endmodule
